// [pfps_dev.sv]
// function end: power state machine, target and initiator gating, pme context
// assumes host keeps recovery delays and legal bus pairings
// Notes on behaviour
// - state changes only by writes, reset or loss of vcc_ok
// - uninitialized D0 answers configuration only
// - active D0 accepts and initiates anything
// - legacy function behaves as active D0
// - D1 allows configuration and class operations
// - D2/D3hot ignore memory, io, interrupts
// - configuration always accepted in D1-D3hot
// - D3cold answers only segment reset
// - software waits recovery time after writes
// - bus clock runs 16 cycles before stop
// - bridge delay also covers downstream functions
// - recovery timed from latest state write
// - wait larger of recovery, bus restore
// - restore time from write or reset
// - no disallowed bus and function pairings
// - D3hot to D0 soft resets, drivers off
// - from D3 only D0 allowed
module pfps_dev (
	pfps_if.dev lnk,
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic legacy_mode,
	input wire logic sup_d1,
	input wire logic sup_d2,
	input wire logic [pfps_pkg::PME_SUP_W-1:0] pme_sup,
	input wire logic pme_sup_cold,
	input wire logic vcc_ok,
	input wire logic fn_irq_req,
	input wire logic fn_mst_req,
	input wire logic fn_mst_class,
	input wire logic pme_event,
	output logic fn_mst_gnt,
	output logic [1:0] power_state_field,
	output logic fn_active,
	output logic ctx_clr,
	output logic pme_status
);
	typedef enum logic [2:0] {
		ST_D0U,
		ST_D0A,
		ST_D1,
		ST_D2,
		ST_D3H,
		ST_SRST,
		ST_D3C
	} pfps_dst_t;

	pfps_dst_t st_ff;
	pfps_dst_t nxt_st;
	logic [4:0] srst_cnt_ff;
	logic pme_en_ff;
	logic pme_status_ff;
	logic rsp_valid_ff;
	logic rsp_claim_ff;
	logic [1:0] rsp_data_ff;
	logic irq_ff;
	logic mst_req_ff;
	logic mst_class_ff;
	logic ctx_clr_ff;
	logic ps_wr;
	logic drv_on;
	logic act;

	function automatic logic [1:0] ps_of(input pfps_dst_t s);
		unique case (s)
			ST_D0U, ST_D0A, ST_SRST: ps_of = pfps_pkg::PS_D0;
			ST_D1: ps_of = pfps_pkg::PS_D1;
			ST_D2: ps_of = pfps_pkg::PS_D2;
			ST_D3H, ST_D3C: ps_of = pfps_pkg::PS_D3;
		endcase
	endfunction : ps_of

	// unsupported targets and any exit from D3hot other than D0 are dropped
	function automatic logic ps_ok(input pfps_dst_t s, input logic [1:0] req, input logic d1, input logic d2);
		ps_ok = 1'b1;
		if (req == pfps_pkg::PS_D1 && !d1)
			ps_ok = 1'b0;
		if (req == pfps_pkg::PS_D2 && !d2)
			ps_ok = 1'b0;
		if (s == ST_D3H && req != pfps_pkg::PS_D0)
			ps_ok = 1'b0;
	endfunction : ps_ok

	function automatic pfps_dst_t ps_next(input pfps_dst_t s, input logic [1:0] req);
		unique case (req)
			pfps_pkg::PS_D0:
			begin
				if (s == ST_D3H)
					ps_next = ST_SRST;
				else if (s == ST_D0U)
					ps_next = ST_D0U;
				else
					ps_next = ST_D0A;
			end
			pfps_pkg::PS_D1: ps_next = ST_D1;
			pfps_pkg::PS_D2: ps_next = ST_D2;
			pfps_pkg::PS_D3: ps_next = ST_D3H;
		endcase
	endfunction : ps_next

	// target acceptance per state
	function automatic logic acc(input pfps_dst_t s, input pfps_pkg::pfps_op_t op, input logic leg);
		logic cfg;
		cfg = (op == pfps_pkg::OP_CFG_RD) || (op == pfps_pkg::OP_PS_WR) || (op == pfps_pkg::OP_INIT)
			|| (op == pfps_pkg::OP_PME_CLR) || (op == pfps_pkg::OP_PME_EN);
		if (leg)
			acc = 1'b1;
		else
		begin
			unique case (s)
				ST_D0A: acc = 1'b1;
				ST_D0U: acc = cfg;
				ST_D1: acc = cfg || (op == pfps_pkg::OP_CLASS);
				ST_D2, ST_D3H: acc = cfg;
				ST_SRST, ST_D3C: acc = 1'b0;
			endcase
		end
	endfunction : acc

	function automatic logic pme_ok(input pfps_dst_t s, input logic [pfps_pkg::PME_SUP_W-1:0] sup, input logic cold);
		unique case (s)
			ST_D0U: pme_ok = sup[0];
			ST_D0A: pme_ok = sup[1];
			ST_D1: pme_ok = sup[2];
			ST_D2: pme_ok = sup[3];
			ST_D3H, ST_SRST: pme_ok = sup[4];
			ST_D3C: pme_ok = cold;
		endcase
	endfunction : pme_ok

	assign drv_on = (st_ff != ST_SRST) && (st_ff != ST_D3C);
	assign act = legacy_mode || (st_ff == ST_D0A);
	assign ps_wr = lnk.cmd_valid && lnk.cmd_op == pfps_pkg::OP_PS_WR && drv_on && !legacy_mode;

	always_comb
	begin
		nxt_st = st_ff;
		if (!vcc_ok)
			nxt_st = ST_D3C;
		else if (lnk.seg_rst)
			nxt_st = ST_D0U;
		else
		begin
			unique case (st_ff)
				ST_SRST:
				begin
					if (srst_cnt_ff == 5'h0)
						nxt_st = ST_D0U;
				end
				ST_D3C: nxt_st = ST_D3C;
				ST_D0U, ST_D0A, ST_D1, ST_D2, ST_D3H:
				begin
					if (ps_wr && ps_ok(st_ff, lnk.cmd_data, sup_d1, sup_d2))
						nxt_st = ps_next(st_ff, lnk.cmd_data);
					else if (lnk.cmd_valid && lnk.cmd_op == pfps_pkg::OP_INIT && st_ff == ST_D0U)
						nxt_st = ST_D0A;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			st_ff <= ST_D0U;
		else
			st_ff <= nxt_st;
	end

	// soft reset length; drivers stay off for all of it
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			srst_cnt_ff <= 5'h0;
		else if (nxt_st == ST_SRST && st_ff != ST_SRST)
			srst_cnt_ff <= pfps_pkg::SRST_CYC - 5'h1;
		else if (srst_cnt_ff != 5'h0)
			srst_cnt_ff <= srst_cnt_ff - 5'h1;
	end

	// context is lost on soft reset and segment reset, pme context survives
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			ctx_clr_ff <= 1'b0;
		else
			ctx_clr_ff <= (nxt_st == ST_SRST && st_ff != ST_SRST) || (nxt_st == ST_D0U && st_ff != ST_D0U);
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pme_en_ff <= 1'b0;
		else if (lnk.cmd_valid && lnk.cmd_op == pfps_pkg::OP_PME_EN && drv_on)
			pme_en_ff <= lnk.cmd_data[0];
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pme_status_ff <= 1'b0;
		else if (pme_event && pme_en_ff && pme_ok(st_ff, pme_sup, pme_sup_cold))
			pme_status_ff <= 1'b1;
		else if (lnk.cmd_valid && lnk.cmd_op == pfps_pkg::OP_PME_CLR && drv_on)
			pme_status_ff <= 1'b0;
	end

	// silent when drivers are off, so the host sees no answer at all
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_claim_ff <= 1'b0;
			rsp_data_ff <= 2'h0;
		end
		else
		begin
			rsp_valid_ff <= lnk.cmd_valid && drv_on;
			rsp_claim_ff <= lnk.cmd_valid && acc(st_ff, lnk.cmd_op, legacy_mode);
			rsp_data_ff <= (lnk.cmd_op == pfps_pkg::OP_CFG_RD) ? ps_of(st_ff) : 2'h0;
		end
	end

	// initiator gating
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			irq_ff <= 1'b0;
			mst_req_ff <= 1'b0;
			mst_class_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= fn_irq_req && act;
			mst_req_ff <= fn_mst_req && (act || (fn_mst_class && st_ff == ST_D1));
			mst_class_ff <= fn_mst_class;
		end
	end

	assign lnk.rsp_valid = rsp_valid_ff;
	assign lnk.rsp_claim = rsp_claim_ff;
	assign lnk.rsp_data = rsp_data_ff;
	assign lnk.irq = irq_ff;
	assign lnk.mst_req = mst_req_ff;
	assign lnk.mst_class = mst_class_ff;
	assign lnk.drv_en = drv_on;
	assign lnk.pme_n_o = 1'b0;
	assign lnk.pme_oe_n = !pme_status_ff;
	assign fn_mst_gnt = mst_req_ff;
	assign power_state_field = ps_of(st_ff);
	assign fn_active = act;
	assign ctx_clr = ctx_clr_ff;
	assign pme_status = pme_status_ff;
endmodule : pfps_dev

// [pfps_pkg.sv]
// constants and types shared by both ends of the function power state link
// assumes one 40 MHz clock shared by both ends
package pfps_pkg;
	localparam int CLK_MHZ = 40;
	localparam int T_D2_US = 200;
	localparam int T_D3_MS = 10;
	localparam int REC_D2_CYC = T_D2_US * CLK_MHZ;
	localparam int REC_D3_CYC = T_D3_MS * 1000 * CLK_MHZ;
	localparam int REC_W = 19;
	localparam logic [4:0] CLK_HOLD_CYC = 5'h10;
	localparam logic [4:0] SRST_CYC = 5'h10;
	localparam logic [2:0] MABORT_CYC = 3'h4;
	localparam int RESTORE_W = 24;
	localparam int PME_SUP_W = 5;

	typedef enum logic [1:0] {
		PS_D0 = 2'h0,
		PS_D1 = 2'h1,
		PS_D2 = 2'h2,
		PS_D3 = 2'h3
	} pfps_ps_t;

	typedef enum logic [1:0] {
		BUS_B0 = 2'h0,
		BUS_B1 = 2'h1,
		BUS_B2 = 2'h2,
		BUS_B3 = 2'h3
	} pfps_bus_t;

	typedef enum logic [2:0] {
		OP_CFG_RD = 3'h0,
		OP_PS_WR = 3'h1,
		OP_INIT = 3'h2,
		OP_PME_CLR = 3'h3,
		OP_PME_EN = 3'h4,
		OP_MEM = 3'h5,
		OP_IO = 3'h6,
		OP_CLASS = 3'h7
	} pfps_op_t;
endpackage : pfps_pkg

// [pfps_if.sv]
// link between the power state controller of a function and its host side
// assumes both ends run on the same clk_sys
interface pfps_if;
	logic cmd_valid;
	pfps_pkg::pfps_op_t cmd_op;
	logic [1:0] cmd_data;
	logic seg_rst;
	logic clk_run;
	logic rsp_valid;
	logic rsp_claim;
	logic [1:0] rsp_data;
	logic irq;
	logic mst_req;
	logic mst_class;
	logic drv_en;
	logic pme_n_o;
	logic pme_oe_n;
	logic pme_n;

	// open-drain wire with its pull-up
	assign pme_n = pme_oe_n ? 1'b1 : pme_n_o;

	modport dev (
		input cmd_valid, cmd_op, cmd_data, seg_rst, clk_run,
		output rsp_valid, rsp_claim, rsp_data, irq, mst_req, mst_class, drv_en, pme_n_o, pme_oe_n
	);
	modport host (
		output cmd_valid, cmd_op, cmd_data, seg_rst, clk_run,
		input rsp_valid, rsp_claim, rsp_data, irq, mst_req, mst_class, drv_en, pme_n
	);
endinterface : pfps_if

// [pfps_host.sv]
// host end: issues accesses, keeps recovery waits, clock hold and pairings
// assumes the function answers the cycle after a command or not at all
module pfps_host #(
	parameter int REC_D2 = pfps_pkg::REC_D2_CYC,
	parameter int REC_D3 = pfps_pkg::REC_D3_CYC
) (
	pfps_if.host lnk,
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sw_valid,
	input wire logic [2:0] sw_op,
	input wire logic [1:0] sw_data,
	output logic sw_ready,
	output logic sw_refused,
	output logic sw_rsp_valid,
	output logic sw_rsp_claim,
	output logic [1:0] sw_rsp_data,
	input wire logic [1:0] bus_state,
	input wire logic is_bridge,
	input wire logic clk_stop_req,
	input wire logic seg_rst_req,
	output logic recover_busy,
	output logic downstream_ok,
	output logic [pfps_pkg::RESTORE_W-1:0] restore_cyc,
	output logic dev_irq,
	output logic dev_pme
);
	logic [1:0] st_ff;
	logic [pfps_pkg::REC_W-1:0] rec_cnt_ff;
	logic [pfps_pkg::REC_W-1:0] nxt_rec;
	logic [4:0] hold_cnt_ff;
	logic cmd_valid_ff;
	logic [2:0] cmd_op_ff;
	logic [1:0] cmd_data_ff;
	logic pend_ff;
	logic [2:0] to_cnt_ff;
	logic rsp_v_ff;
	logic rsp_c_ff;
	logic [1:0] rsp_d_ff;
	logic refused_ff;
	logic clk_run_ff;
	logic seg_rst_ff;
	logic restore_run_ff;
	logic [pfps_pkg::RESTORE_W-1:0] restore_ff;
	logic [2:0] pme_sync_ff;
	logic pme_ff;
	logic is_ps;
	logic bad;
	logic take;

	assign is_ps = sw_op == pfps_pkg::OP_PS_WR;
	// pairings of bus and function state, and exits from D3
	assign bad = is_ps && ((sw_data == pfps_pkg::PS_D0 && bus_state != pfps_pkg::BUS_B0)
		|| (sw_data == pfps_pkg::PS_D1 && bus_state[1])
		|| (sw_data[1] && bus_state == pfps_pkg::BUS_B3)
		|| (st_ff == pfps_pkg::PS_D3 && sw_data != pfps_pkg::PS_D0));
	// bus restore gate plus recovery wait, whichever ends later
	assign sw_ready = rec_cnt_ff == '0 && bus_state == pfps_pkg::BUS_B0 && !pend_ff && !cmd_valid_ff;
	assign take = sw_valid && sw_ready && !bad;

	always_comb
	begin
		nxt_rec = '0;
		if (st_ff == pfps_pkg::PS_D3 || sw_data == pfps_pkg::PS_D3)
			nxt_rec = pfps_pkg::REC_W'(REC_D3);
		else if (st_ff == pfps_pkg::PS_D2 || sw_data == pfps_pkg::PS_D2)
			nxt_rec = pfps_pkg::REC_W'(REC_D2);
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			st_ff <= pfps_pkg::PS_D0;
		else if (seg_rst_req)
			st_ff <= pfps_pkg::PS_D0;
		else if (take && is_ps)
			st_ff <= sw_data;
	end

	// restarted by every write, never extended past the latest one
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			rec_cnt_ff <= '0;
		else if (take && is_ps)
			rec_cnt_ff <= nxt_rec;
		else if (rec_cnt_ff != '0)
			rec_cnt_ff <= rec_cnt_ff - 1'b1;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			hold_cnt_ff <= 5'h0;
		else if (take && is_ps && sw_data[1])
			hold_cnt_ff <= pfps_pkg::CLK_HOLD_CYC;
		else if (hold_cnt_ff != 5'h0)
			hold_cnt_ff <= hold_cnt_ff - 5'h1;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			clk_run_ff <= 1'b1;
		else
			clk_run_ff <= !(clk_stop_req && hold_cnt_ff == 5'h0 && !(take && is_ps));
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cmd_valid_ff <= 1'b0;
			cmd_op_ff <= 3'h0;
			cmd_data_ff <= 2'h0;
			refused_ff <= 1'b0;
			seg_rst_ff <= 1'b0;
		end
		else
		begin
			cmd_valid_ff <= take;
			if (take)
			begin
				cmd_op_ff <= sw_op;
				cmd_data_ff <= sw_data;
			end
			refused_ff <= sw_valid && sw_ready && bad;
			seg_rst_ff <= seg_rst_req;
		end
	end

	// no answer within the window counts as not claimed
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pend_ff <= 1'b0;
			to_cnt_ff <= 3'h0;
			rsp_v_ff <= 1'b0;
			rsp_c_ff <= 1'b0;
			rsp_d_ff <= 2'h0;
		end
		else
		begin
			rsp_v_ff <= 1'b0;
			if (cmd_valid_ff)
			begin
				pend_ff <= 1'b1;
				to_cnt_ff <= pfps_pkg::MABORT_CYC;
			end
			else if (pend_ff && (lnk.rsp_valid || to_cnt_ff == 3'h0))
			begin
				pend_ff <= 1'b0;
				rsp_v_ff <= 1'b1;
				rsp_c_ff <= lnk.rsp_valid && lnk.rsp_claim;
				rsp_d_ff <= lnk.rsp_valid ? lnk.rsp_data : 2'h0;
			end
			else if (pend_ff)
				to_cnt_ff <= to_cnt_ff - 3'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			restore_run_ff <= 1'b0;
			restore_ff <= '0;
		end
		else if (seg_rst_req || (take && is_ps && sw_data == pfps_pkg::PS_D0))
		begin
			restore_run_ff <= 1'b1;
			restore_ff <= '0;
		end
		else if (take && sw_op == pfps_pkg::OP_INIT)
			restore_run_ff <= 1'b0;
		else if (restore_run_ff)
			restore_ff <= restore_ff + 1'b1;
	end

	// pme wire is asynchronous to the clock
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pme_sync_ff <= 3'h7;
			pme_ff <= 1'b0;
		end
		else
		begin
			pme_sync_ff <= {pme_sync_ff[1:0], lnk.pme_n};
			if (pme_sync_ff[1] == pme_sync_ff[2])
				pme_ff <= !pme_sync_ff[2];
		end
	end

	assign lnk.cmd_valid = cmd_valid_ff;
	assign lnk.cmd_op = pfps_pkg::pfps_op_t'(cmd_op_ff);
	assign lnk.cmd_data = cmd_data_ff;
	assign lnk.seg_rst = seg_rst_ff;
	assign lnk.clk_run = clk_run_ff;
	assign sw_refused = refused_ff;
	assign sw_rsp_valid = rsp_v_ff;
	assign sw_rsp_claim = rsp_c_ff;
	assign sw_rsp_data = rsp_d_ff;
	assign recover_busy = rec_cnt_ff != '0;
	assign downstream_ok = !(is_bridge && rec_cnt_ff != '0);
	assign restore_cyc = restore_ff;
	assign dev_irq = lnk.irq;
	assign dev_pme = pme_ff;
endmodule : pfps_host

// [pfps_assertions.sv]
// concurrent checks on the link between host end and function end
// assumes one clock domain and instantiation beside the link interface
module pfps_assertions (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire pfps_pkg::pfps_op_t cmd_op,
	input wire logic [1:0] cmd_data,
	input wire logic seg_rst,
	input wire logic clk_run,
	input wire logic rsp_valid,
	input wire logic rsp_claim,
	input wire logic [1:0] rsp_data,
	input wire logic irq,
	input wire logic mst_req,
	input wire logic drv_en,
	input wire logic pme_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;

	pfps_pkg::pfps_op_t op_ff;
	logic [1:0] dat_ff;
	logic [1:0] ps_ff;
	logic [4:0] hold_ff;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			op_ff <= pfps_pkg::OP_CFG_RD;
			dat_ff <= 2'h0;
		end
		else if (cmd_valid)
		begin
			op_ff <= cmd_op;
			dat_ff <= cmd_data;
		end
	end

	// shadow of the state field, only claimed writes count
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			ps_ff <= 2'h0;
		else if (seg_rst)
			ps_ff <= 2'h0;
		else if (rsp_valid && rsp_claim && op_ff == pfps_pkg::OP_PS_WR)
			ps_ff <= dat_ff;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			hold_ff <= 5'h00;
		else if (cmd_valid && cmd_op == pfps_pkg::OP_PS_WR && cmd_data[1])
			hold_ff <= pfps_pkg::CLK_HOLD_CYC;
		else if (hold_ff != 5'h00)
			hold_ff <= hold_ff - 5'h01;
	end

	rsp_after_cmd_a: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without a command");
	cfg_answered_a: assert property (cmd_valid && cmd_op == pfps_pkg::OP_CFG_RD && drv_en |=> rsp_valid && rsp_claim)
		else $error("configuration read not claimed");
	drv_off_silent_a: assert property (cmd_valid && !drv_en |=> !rsp_valid)
		else $error("answer while drivers off");
	cfg_data_a: assert property (rsp_valid && op_ff == pfps_pkg::OP_CFG_RD |-> rsp_data == ps_ff)
		else $error("state readback differs from last write");
	mem_ignored_a: assert property (rsp_valid && ps_ff[1] && (op_ff == pfps_pkg::OP_MEM || op_ff == pfps_pkg::OP_IO) |-> !rsp_claim)
		else $error("memory or io claimed in low power");
	irq_gate_a: assert property (ps_ff != 2'h0 |-> !irq)
		else $error("interrupt outside active state");
	mst_gate_a: assert property (ps_ff[1] |-> !mst_req)
		else $error("bus mastering in deep state");
	clk_hold_a: assert property (hold_ff != 5'h00 |-> clk_run)
		else $error("clock stopped too soon");
	pme_hold_a: assert property (!pme_oe_n && !(cmd_valid && cmd_op == pfps_pkg::OP_PME_CLR) |=> !pme_oe_n)
		else $error("event released without clear");
endmodule : pfps_assertions

// [test_pci_function_power_state_policy.sv]
// self-checking bench: host end and function end joined by the link
// assumes host user side protocol as handed over, recovery shortened
module test_pci_function_power_state_policy;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, reset, sw_valid, is_bridge, clk_stop_req, seg_rst_req, legacy_mode, sup_d1, sup_d2;
	logic pme_sup_cold, vcc_ok, fn_irq_req, fn_mst_req, fn_mst_class, pme_event;
	logic sw_ready, sw_refused, sw_rsp_valid, sw_rsp_claim, recover_busy, dev_irq, dev_pme, fn_mst_gnt;
	logic pme_status, r_claim, r_ref, downstream_ok, fn_active;
	logic [pfps_pkg::RESTORE_W-1:0] restore_cyc;
	logic [2:0] sw_op;
	logic [1:0] sw_data, bus_state, sw_rsp_data, power_state_field, r_data;
	logic [4:0] pme_sup;
	int n_fail, samples_checked, cyc;
	pfps_pkg::pfps_op_t tl[3] = '{pfps_pkg::OP_MEM, pfps_pkg::OP_IO, pfps_pkg::OP_CLASS};

	pfps_if pfps_if_inst ();
	pfps_host #(.REC_D2(20), .REC_D3(40)) pfps_host_inst (.lnk(pfps_if_inst), .clk_sys(clk_sys), .reset(reset),
		.sw_valid(sw_valid), .sw_op(sw_op), .sw_data(sw_data), .sw_ready(sw_ready), .sw_refused(sw_refused),
		.sw_rsp_valid(sw_rsp_valid), .sw_rsp_claim(sw_rsp_claim), .sw_rsp_data(sw_rsp_data),
		.bus_state(bus_state), .is_bridge(is_bridge), .clk_stop_req(clk_stop_req), .seg_rst_req(seg_rst_req),
		.recover_busy(recover_busy), .downstream_ok(downstream_ok), .restore_cyc(restore_cyc), .dev_irq(dev_irq),
		.dev_pme(dev_pme));
	pfps_dev pfps_dev_inst (.lnk(pfps_if_inst), .clk_sys(clk_sys), .reset(reset), .legacy_mode(legacy_mode),
		.sup_d1(sup_d1), .sup_d2(sup_d2), .pme_sup(pme_sup), .pme_sup_cold(pme_sup_cold), .vcc_ok(vcc_ok),
		.fn_irq_req(fn_irq_req), .fn_mst_req(fn_mst_req), .fn_mst_class(fn_mst_class), .pme_event(pme_event),
		.fn_mst_gnt(fn_mst_gnt), .power_state_field(power_state_field), .fn_active(fn_active), .ctx_clr(),
		.pme_status(pme_status));
	pfps_assertions pfps_assertions_inst (.clk_sys(clk_sys), .reset(reset), .cmd_valid(pfps_if_inst.cmd_valid),
		.cmd_op(pfps_if_inst.cmd_op), .cmd_data(pfps_if_inst.cmd_data), .seg_rst(pfps_if_inst.seg_rst),
		.clk_run(pfps_if_inst.clk_run), .rsp_valid(pfps_if_inst.rsp_valid), .rsp_claim(pfps_if_inst.rsp_claim),
		.rsp_data(pfps_if_inst.rsp_data), .irq(pfps_if_inst.irq), .mst_req(pfps_if_inst.mst_req),
		.drv_en(pfps_if_inst.drv_en), .pme_oe_n(pfps_if_inst.pme_oe_n));

	always #12.5 clk_sys = ~clk_sys;

	task stop_test;
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	// one request, held until the host is ready, then the answer or refusal is collected
	task op(input pfps_pkg::pfps_op_t o, input logic [1:0] d);
		int n;
		n = 0;
		sw_valid <= 1'b1;
		sw_op <= o;
		sw_data <= d;
		@(posedge clk_sys);
		while (sw_ready !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		// a request the host is never ready for within 100 cycles counts as a failure
		if (n == 100)
			n_fail++;
		sw_valid <= 1'b0;
		r_ref = 1'b0;
		r_claim = 1'b0;
		repeat (10)
		begin
			@(posedge clk_sys);
			if (sw_rsp_valid === 1'b1 || sw_refused === 1'b1)
			begin
				r_ref = sw_refused;
				r_claim = sw_rsp_claim;
				r_data = sw_rsp_data;
				break;
			end
		end
	endtask : op

	task seg_pulse;
		seg_rst_req <= 1'b1;
		wt(3);
		seg_rst_req <= 1'b0;
		wt(3);
	endtask : seg_pulse

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		{clk_sys, sw_valid, sw_op, sw_data, bus_state, clk_stop_req, seg_rst_req} = '0;
		{legacy_mode, pme_event, fn_mst_class} = '0;
		{sup_d1, sup_d2, pme_sup_cold, vcc_ok, fn_irq_req, fn_mst_req, reset, is_bridge} = '1;
		pme_sup = 5'h1f;
		wt(6);
		reset <= 1'b0;
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("cfg claim d0u", r_claim, 2'h1);
		op(pfps_pkg::OP_MEM, 2'h0);
		chk("mem claim d0u", r_claim, 2'h0);
		chk("irq d0u", dev_irq, 2'h0);
		op(pfps_pkg::OP_INIT, 2'h0);
		op(pfps_pkg::OP_PME_EN, 2'h1);
		foreach (tl[i])
		begin
			op(tl[i], 2'h0);
			chk("claim d0a", r_claim, 2'h1);
		end
		chk("irq d0a", dev_irq, 2'h1);
		chk("grant d0a", fn_mst_gnt, 2'h1);
		chk("active d0a", fn_active, 2'h1);
		fn_mst_class <= 1'b1;
		op(pfps_pkg::OP_PS_WR, 2'h1);
		chk("busy d1", recover_busy, 2'h0);
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("state d1", r_data, 2'h1);
		op(pfps_pkg::OP_CLASS, 2'h0);
		chk("class d1", r_claim, 2'h1);
		op(pfps_pkg::OP_MEM, 2'h0);
		chk("mem d1", r_claim, 2'h0);
		chk("irq d1", dev_irq, 2'h0);
		chk("active d1", fn_active, 2'h0);
		clk_stop_req <= 1'b1;
		op(pfps_pkg::OP_PS_WR, 2'h2);
		wt(10);
		chk("busy d2 early", recover_busy, 2'h1);
		chk("downstream d2 early", downstream_ok, 2'h0);
		wt(12);
		chk("busy d2 late", recover_busy, 2'h0);
		chk("downstream d2 late", downstream_ok, 2'h1);
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("state d2", r_data, 2'h2);
		foreach (tl[i])
		begin
			op(tl[i], 2'h0);
			chk("claim d2", r_claim, 2'h0);
		end
		chk("irq d2", dev_irq, 2'h0);
		chk("grant d2", fn_mst_gnt, 2'h0);
		op(pfps_pkg::OP_PS_WR, 2'h3);
		wt(30);
		chk("busy d3", recover_busy, 2'h1);
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("state d3", r_data, 2'h3);
		pme_event <= 1'b1;
		wt(1);
		pme_event <= 1'b0;
		wt(6);
		chk("pme d3", dev_pme, 2'h1);
		op(pfps_pkg::OP_PS_WR, 2'h1);
		chk("refuse d3 to d1", r_ref, 2'h1);
		op(pfps_pkg::OP_PS_WR, 2'h0);
		chk("drivers off", pfps_if_inst.drv_en, 2'h0);
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("state after soft reset", r_data, 2'h0);
		op(pfps_pkg::OP_MEM, 2'h0);
		chk("mem after soft reset", r_claim, 2'h0);
		chk("pme kept", pme_status, 2'h1);
		op(pfps_pkg::OP_PME_CLR, 2'h0);
		wt(6);
		chk("pme cleared", dev_pme, 2'h0);
		op(pfps_pkg::OP_INIT, 2'h0);
		// restore covers at least the shortened d3 recovery of 40 cycles
		chk("restore time", restore_cyc >= 24'h28, 2'h1);
		op(pfps_pkg::OP_PS_WR, 2'h1);
		seg_pulse();
		chk("state after seg reset", power_state_field, 2'h0);
		legacy_mode <= 1'b1;
		op(pfps_pkg::OP_MEM, 2'h0);
		chk("mem legacy", r_claim, 2'h1);
		wt(3);
		chk("irq legacy", dev_irq, 2'h1);
		legacy_mode <= 1'b0;
		bus_state <= 2'h1;
		wt(3);
		chk("ready bus b1", sw_ready, 2'h0);
		bus_state <= 2'h0;
		vcc_ok <= 1'b0;
		wt(3);
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("cfg d3cold", r_claim, 2'h0);
		vcc_ok <= 1'b1;
		seg_pulse();
		op(pfps_pkg::OP_CFG_RD, 2'h0);
		chk("cfg after power", r_claim, 2'h1);
		// last step: the checker's shadow cannot know d2 is unsupported
		sup_d2 <= 1'b0;
		op(pfps_pkg::OP_PS_WR, 2'h2);
		chk("unsupported claimed", r_claim, 2'h1);
		chk("unsupported d2", power_state_field, 2'h0);
		stop_test();
	end
endmodule : test_pci_function_power_state_policy
